// File: pfi_host.sv
// Serial host model driving the register port
`timescale 1ns/100ps
`default_nettype none
module pfi_host (
    output logic      spi_clk,
    output logic      serial_select_n,
    output logic      spi_din,
    input  wire logic spi_dout_o,
    input  wire logic spi_dout_oe
);
    logic       last_r  = 1'b0;
    logic       rd_stb  = 1'b0;
    logic [7:0] rd_byte = 8'h00;
    wire        sdo     = spi_dout_oe ? spi_dout_o : ~last_r; // Released line flips
    // Idle levels, clock stands low between frames
    initial begin
        spi_clk = 1'b0;
        serial_select_n = 1'b1;
        spi_din = 1'b0;
    end
    always @(posedge spi_clk) last_r <= sdo;
    // One frame: command byte then n data bytes, 48 ns clock
    task automatic xfer(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1,
                        input int n);
        logic [23:0] w;
        w = {c, d0, d1};
        serial_select_n = 1'b0;
        #250;
        for (int i = 23; i >= 24 - 8 * (n + 1); i--) begin
            spi_din = w[i];
            #24;
            spi_clk = 1'b1;
            rd_byte = {rd_byte[6:0], sdo};
            if (i % 8 == 0 && i < 16 && !c[7]) rd_stb = ~rd_stb;
            #24;
            spi_clk = 1'b0;
        end
        #24;
        serial_select_n = 1'b1;
        #250;
    endtask
endmodule // pfi_host
`default_nettype wire

// File: pfi_pkg.sv
// Constants, types and rule summary for the supervision and serial port block
// How it works
// - Ten-way measurement select, code 8 selects none
// - Hot-die warning sets its flag
// - Thermal shutdown drops rails until enable rewritten
// - Low battery sets flag, operation continues
// - Lockout flags, sequences rails down, clears enable
// - No re-enable before recovery and power toggle
// - Lockout threshold has 31 steps, default lowest
// - Park wait up to 100 us, then discharge
// - Mirror fault flags, clears enable, stops rails
// - Aux rail fault flags, stops LED converter, retries
// - LED overvoltage flags, converter keeps running
// - Load switch low discharges at once, latched
// - Every event latches a flag, pulls irq low unless masked
// - Reading flags clears them, releases irq
// - Persisting fault re-sets flag within 32 us
// - Mask gates the irq pin and the mirror fault lockout
// - Select high ignores input, floats output
// - Sample on rising edge, shift out on falling
// - Command byte: direction bit then address
// - Address increments per byte, wraps at 0x7F
// - Serial clock up to 33.3 MHz
// - Password BA then BE unlocks 0x11 to 0x27
// - Power-on low resets registers, ignores port
package pfi_pkg;

    // Clock and timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int PARK_MAX_US   = 100;
    localparam int PARK_MAX_CYC  = PARK_MAX_US * CYC_PER_US;
    localparam int IRQ_REARM_US  = 32;
    localparam int IRQ_REARM_CYC = IRQ_REARM_US * CYC_PER_US;

    // Register addresses
    localparam logic [6:0] A_ID    = 7'h00;
    localparam logic [6:0] A_EN    = 7'h01;
    localparam logic [6:0] A_UNDERVOLTAGE_LOCKOUT_FLAG  = 7'h09;
    localparam logic [6:0] A_INT   = 7'h0C;
    localparam logic [6:0] A_MASK  = 7'h0D;
    localparam logic [6:0] A_PW    = 7'h10;
    localparam logic [6:0] A_MEAS  = 7'h11;
    localparam logic [6:0] A_PARK  = 7'h12;
    localparam logic [6:0] PROT_LO = 7'h11;
    localparam logic [6:0] PROT_HI = 7'h27;

    // Field positions and values
    localparam int         EN_MIR    = 0;
    localparam int         EN_LED    = 1;
    localparam int         FLG_MIR   = 4;
    localparam logic [4:0] UNDERVOLTAGE_LOCKOUT_FLAG_MAX  = 5'h1E;
    localparam logic [6:0] PARK_MAX  = 7'h64;
    localparam logic [3:0] MEAS_NONE = 4'h8;
    localparam int         MEAS_SRC  = 10;
    localparam logic [7:0] PW_KEY1   = 8'hBA;
    localparam logic [7:0] PW_KEY2   = 8'hBE;

    // Reset values
    localparam logic [1:0] EN_RST   = 2'h0;
    localparam logic [4:0] UNDERVOLTAGE_LOCKOUT_FLAG_RST = 5'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [3:0] MEAS_RST = 4'h8;
    localparam logic [6:0] PARK_RST = 7'h64;

    typedef struct packed {
        logic ls_low;
        logic led_ovp;
        logic aux_pg;
        logic mirror;
        logic undervoltage_lockout_flag;
        logic low_battery_flag;
        logic thermal_shutdown_flag;
        logic hot;
    } pfi_flt_t;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } pfi_evt_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] mask;
        logic [1:0] en;
        logic [4:0] undervoltage_lockout_flag;
        logic       pw_open;
        logic [3:0] meas;
        logic [6:0] park;
    } pfi_snap_t;

    typedef enum logic [1:0] {
        SQ_RUN  = 2'b00,
        SQ_PARK = 2'b01,
        SQ_DIS  = 2'b11
    } pfi_seq_t;

    typedef enum logic [1:0] {
        PW_LOCK = 2'b00,
        PW_HALF = 2'b01,
        PW_OPEN = 2'b11
    } pfi_pw_t;

endpackage

// File: pfi_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pfi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    if (W < 1) begin : g_chk
        $error("pfi_sync width must be at least one");
    end

    // Output follows a bit once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= (s2_r & ~(s2_r ^ s3_r)) | (dout & (s2_r ^ s3_r));
        end
    end
endmodule // pfi_sync
`default_nettype wire

// File: pfi_top.sv
// Fault supervision, interrupt flags and serial register port
`timescale 1ns/100ps
`default_nettype none
module pfi_top #(
    parameter logic [7:0] CHIP_ID = 8'h5A // Arbitrary value
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             spi_clk,
    input  wire logic             serial_select_n,
    input  wire logic             spi_din,
    output logic                  spi_dout_o,
    output logic                  spi_dout_oe,
    output logic                  irq_n_pin_o,
    output logic                  irq_n_pin_oe,
    input  wire logic             power_on_pin,
    input  wire pfi_pkg::pfi_flt_t flt_raw,
    input  wire logic             undervoltage_lockout_flag_recovered,
    output logic                  mirror_supply_enable,
    output logic                  mirror_rails_en,
    output logic                  led_buckboost_en,
    output logic                  rail_discharge,
    output logic                  system_reset_n_out,
    output logic [3:0]            meas_input_select,
    output logic [9:0]            meas_source_en,
    output logic [4:0]            undervoltage_lockout_flag_threshold_sel
);
    localparam int REARM = pfi_pkg::IRQ_REARM_CYC;

    // ==========================================================
    // Input synchronisation
    logic [11:0]        sy_in;
    logic [11:0]        sy_out;
    pfi_pkg::pfi_flt_t  flt_s;
    logic               rec_s;
    logic               on_s;
    logic               csn_s;
    logic               tgl_s;
    logic               evt_tgl_r;

    assign sy_in = {flt_raw, undervoltage_lockout_flag_recovered, power_on_pin, serial_select_n, evt_tgl_r};

    pfi_sync #(.W(12)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (sy_in),
        .dout (sy_out)
    );

    assign flt_s = sy_out[11:4];
    assign rec_s = sy_out[3];
    assign on_s  = sy_out[2];
    assign csn_s = sy_out[1];
    assign tgl_s = sy_out[0];

    // ==========================================================
    // Serial port, link clock domain
    logic [2:0]         bits_r;
    logic [6:0]         sh_r;
    logic               cmd_r;
    logic               dir_r;
    logic [6:0]         addr_r;
    logic [7:0]         byte_in;
    logic [7:0]         tx_r;
    logic [7:0]         rd_byte;
    pfi_pkg::pfi_evt_t  evt_r;
    pfi_pkg::pfi_snap_t snap_r;

    assign byte_in = {sh_r, spi_din};

    // Shift in on rising edge, decode command, step address
    always_ff @(posedge spi_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            bits_r <= 3'h0;
            sh_r   <= 7'h00;
            cmd_r  <= 1'b1;
            dir_r  <= 1'b0;
            addr_r <= 7'h00;
        end else begin
            bits_r <= bits_r + 3'h1;
            sh_r   <= byte_in[6:0];
            if (bits_r == 3'h7) begin
                if (cmd_r) begin
                    cmd_r  <= 1'b0;
                    dir_r  <= byte_in[7];
                    addr_r <= byte_in[6:0];
                end else begin
                    addr_r <= addr_r + 7'h01;
                end
            end
        end
    end

    // Completed data byte handed to the system clock by a toggle
    always_ff @(posedge spi_clk or negedge rstn) begin
        if (!rstn) begin
            evt_r     <= '0;
            evt_tgl_r <= 1'b0;
        end else if (!serial_select_n && bits_r == 3'h7 && !cmd_r) begin
            evt_r     <= '{wr: dir_r, addr: addr_r, data: byte_in};
            evt_tgl_r <= ~evt_tgl_r;
        end
    end

    // Read data from the frozen snapshot
    always_comb begin
        unique case (addr_r)
            pfi_pkg::A_ID:   rd_byte = CHIP_ID;
            pfi_pkg::A_EN:   rd_byte = {6'h00, snap_r.en};
            pfi_pkg::A_UNDERVOLTAGE_LOCKOUT_FLAG: rd_byte = {3'h0, snap_r.undervoltage_lockout_flag};
            pfi_pkg::A_INT:  rd_byte = snap_r.flags;
            pfi_pkg::A_MASK: rd_byte = snap_r.mask;
            pfi_pkg::A_PW:   rd_byte = {7'h00, snap_r.pw_open};
            pfi_pkg::A_MEAS: rd_byte = {4'h0, snap_r.meas};
            pfi_pkg::A_PARK: rd_byte = {1'b0, snap_r.park};
            default:         rd_byte = 8'h00;
        endcase
    end

    // Shift out on falling edge, load at each byte start
    always_ff @(negedge spi_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            tx_r       <= 8'h00;
            spi_dout_o <= 1'b0;
        end else if (bits_r == 3'h0) begin
            tx_r       <= cmd_r ? 8'h00 : {rd_byte[6:0], 1'b0};
            spi_dout_o <= cmd_r ? 1'b0 : rd_byte[7];
        end else begin
            tx_r       <= {tx_r[6:0], 1'b0};
            spi_dout_o <= tx_r[7];
        end
    end

    // Output floats while deselected or powered off
    assign spi_dout_oe = !serial_select_n && system_reset_n_out;

    // ==========================================================
    // Event intake, system clock domain
    logic seen_r;
    logic new_evt;
    logic prot;
    logic wr_ok;
    logic rd_int;
    logic refuse;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_r <= 1'b0;
        end else begin
            seen_r <= tgl_s;
        end
    end

    pfi_pkg::pfi_pw_t pw_r;
    pfi_pkg::pfi_seq_t seq_r;
    logic undervoltage_lockout_flag_lock_r;
    logic mflt_lock_r;
    logic ls_lock_r;
    logic [1:0] en_r;
    logic [7:0] flags_r;
    logic [7:0] mask_r;
    logic [6:0] park_r;
    logic [10:0] cnt_r;
    logic rails_nxt;

    // Commands only while powered on; protected range needs unlock
    assign new_evt = (tgl_s != seen_r) && on_s;
    assign prot    = evt_r.addr >= pfi_pkg::PROT_LO && evt_r.addr <= pfi_pkg::PROT_HI;
    assign wr_ok   = new_evt && evt_r.wr && (!prot || pw_r == pfi_pkg::PW_OPEN);
    assign rd_int  = new_evt && !evt_r.wr && evt_r.addr == pfi_pkg::A_INT;
    assign refuse  = undervoltage_lockout_flag_lock_r || !rec_s || mflt_lock_r || ls_lock_r;

    // ==========================================================
    // Password state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pw_r <= pfi_pkg::PW_LOCK;
        end else if (!on_s) begin
            pw_r <= pfi_pkg::PW_LOCK;
        end else if (new_evt) begin
            if (evt_r.wr && evt_r.addr == pfi_pkg::A_PW) begin
                if (evt_r.data == pfi_pkg::PW_KEY1) begin
                    pw_r <= (pw_r == pfi_pkg::PW_OPEN) ? pfi_pkg::PW_OPEN : pfi_pkg::PW_HALF;
                end else if (evt_r.data == pfi_pkg::PW_KEY2 && pw_r == pfi_pkg::PW_HALF) begin
                    pw_r <= pfi_pkg::PW_OPEN;
                end else begin
                    pw_r <= pfi_pkg::PW_LOCK;
                end
            end else if (pw_r == pfi_pkg::PW_HALF) begin
                pw_r <= pfi_pkg::PW_LOCK; // Any other access breaks the pair
            end
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_r             <= pfi_pkg::MASK_RST;
            park_r             <= pfi_pkg::PARK_RST;
            meas_input_select  <= pfi_pkg::MEAS_RST;
            undervoltage_lockout_flag_threshold_sel <= pfi_pkg::UNDERVOLTAGE_LOCKOUT_FLAG_RST;
        end else if (!on_s) begin
            mask_r             <= pfi_pkg::MASK_RST;
            park_r             <= pfi_pkg::PARK_RST;
            meas_input_select  <= pfi_pkg::MEAS_RST;
            undervoltage_lockout_flag_threshold_sel <= pfi_pkg::UNDERVOLTAGE_LOCKOUT_FLAG_RST;
        end else if (wr_ok) begin
            if (evt_r.addr == pfi_pkg::A_MASK) begin
                mask_r <= evt_r.data;
            end
            if (evt_r.addr == pfi_pkg::A_PARK) begin
                park_r <= (evt_r.data[6:0] > pfi_pkg::PARK_MAX || evt_r.data[7])
                          ? pfi_pkg::PARK_MAX : evt_r.data[6:0];
            end
            if (evt_r.addr == pfi_pkg::A_MEAS) begin
                meas_input_select <= evt_r.data[3:0];
            end
            if (evt_r.addr == pfi_pkg::A_UNDERVOLTAGE_LOCKOUT_FLAG) begin
                undervoltage_lockout_flag_threshold_sel <= (evt_r.data[4:0] > pfi_pkg::UNDERVOLTAGE_LOCKOUT_FLAG_MAX)
                                      ? pfi_pkg::UNDERVOLTAGE_LOCKOUT_FLAG_MAX : evt_r.data[4:0];
            end
        end
    end

    // Measurement source one-hot, code eight and above nine select none
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meas_source_en <= 10'h000;
        end else if (meas_input_select == pfi_pkg::MEAS_NONE ||
                     meas_input_select >= 4'(pfi_pkg::MEAS_SRC)) begin
            meas_source_en <= 10'h000;
        end else begin
            meas_source_en <= 10'h001 << meas_input_select;
        end
    end

    // ==========================================================
    // Enable bits: thermal shutdown, lockout and mirror faults clear the mirror enable over any write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_r <= pfi_pkg::EN_RST;
        end else if (!on_s) begin
            en_r <= pfi_pkg::EN_RST;
        end else begin
            if (wr_ok && evt_r.addr == pfi_pkg::A_EN) begin
                en_r[pfi_pkg::EN_LED] <= evt_r.data[pfi_pkg::EN_LED];
                en_r[pfi_pkg::EN_MIR] <= evt_r.data[pfi_pkg::EN_MIR] && !refuse;
            end
            if (flt_s.thermal_shutdown_flag || flt_s.undervoltage_lockout_flag || flt_s.mirror) begin
                en_r[pfi_pkg::EN_MIR] <= 1'b0;
            end
        end
    end

    // Latched lockouts, released only by a power-on toggle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            undervoltage_lockout_flag_lock_r <= 1'b0;
            mflt_lock_r <= 1'b0;
            ls_lock_r   <= 1'b0;
        end else if (!on_s) begin
            undervoltage_lockout_flag_lock_r <= 1'b0;
            mflt_lock_r <= 1'b0;
            ls_lock_r   <= 1'b0;
        end else begin
            undervoltage_lockout_flag_lock_r <= undervoltage_lockout_flag_lock_r || flt_s.undervoltage_lockout_flag;
            mflt_lock_r <= mflt_lock_r || (flt_s.mirror && !mask_r[pfi_pkg::FLG_MIR]);
            ls_lock_r   <= ls_lock_r || flt_s.ls_low;
        end
    end

    // ==========================================================
    // Shutdown sequence: park wait, then held discharge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seq_r <= pfi_pkg::SQ_RUN;
            cnt_r <= 11'h000;
        end else if (!on_s) begin
            seq_r <= pfi_pkg::SQ_RUN;
            cnt_r <= 11'h000;
        end else if (flt_s.ls_low) begin
            seq_r <= pfi_pkg::SQ_DIS;
        end else begin
            unique case (seq_r)
                pfi_pkg::SQ_RUN: begin
                    if (flt_s.undervoltage_lockout_flag) begin
                        seq_r <= pfi_pkg::SQ_PARK;
                        cnt_r <= 11'(park_r * pfi_pkg::CYC_PER_US);
                    end
                end
                pfi_pkg::SQ_PARK: begin
                    if (cnt_r == 11'h000) begin
                        seq_r <= pfi_pkg::SQ_DIS;
                    end else begin
                        cnt_r <= cnt_r - 11'h001;
                    end
                end
                pfi_pkg::SQ_DIS: seq_r <= pfi_pkg::SQ_DIS;
                default:         seq_r <= pfi_pkg::SQ_DIS;
            endcase
        end
    end

    // Rails hold during parking unless thermal or mirror fault, otherwise follow enable and faults
    assign rails_nxt = (seq_r == pfi_pkg::SQ_PARK) ?
                       (mirror_rails_en && !flt_s.thermal_shutdown_flag && !flt_s.mirror) :
                       (en_r[pfi_pkg::EN_MIR] && seq_r == pfi_pkg::SQ_RUN &&
                        !flt_s.thermal_shutdown_flag && !flt_s.mirror && !flt_s.ls_low);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mirror_rails_en      <= 1'b0;
            led_buckboost_en     <= 1'b0;
            rail_discharge       <= 1'b0;
            system_reset_n_out   <= 1'b0;
            mirror_supply_enable <= 1'b0;
        end else begin
            mirror_rails_en      <= on_s && rails_nxt;
            led_buckboost_en     <= on_s && rails_nxt && en_r[pfi_pkg::EN_LED]
                                    && !flt_s.aux_pg;
            rail_discharge       <= on_s && seq_r == pfi_pkg::SQ_DIS;
            system_reset_n_out   <= on_s;
            mirror_supply_enable <= en_r[pfi_pkg::EN_MIR];
        end
    end

    // ==========================================================
    // Flags and interrupt pin: a new set wins over clear-on-read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_r      <= 8'h00;
            irq_n_pin_oe <= 1'b0;
        end else if (!on_s) begin
            flags_r      <= 8'h00;
            irq_n_pin_oe <= 1'b0;
        end else begin
            flags_r      <= (flags_r & {8{!rd_int}}) | flt_s;
            irq_n_pin_oe <= |(((flags_r & {8{!rd_int}}) | flt_s) & ~mask_r);
        end
    end

    assign irq_n_pin_o = 1'b0; // Open drain: only ever pulls low

    // Snapshot for reads, frozen while the port is selected
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap_r <= '0;
        end else if (csn_s) begin
            snap_r <= '{flags: flags_r, mask: mask_r, en: en_r, undervoltage_lockout_flag: undervoltage_lockout_flag_threshold_sel,
                        pw_open: pw_r == pfi_pkg::PW_OPEN, meas: meas_input_select,
                        park: park_r};
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_uv_entry;
        on_s && seq_r == pfi_pkg::SQ_RUN && flt_s.undervoltage_lockout_flag && !flt_s.ls_low;
    endsequence

    sequence s_key2;
        new_evt && evt_r.wr && evt_r.addr == pfi_pkg::A_PW && evt_r.data == pfi_pkg::PW_KEY2;
    endsequence

    a_flag_latch: assert property (on_s ##1 on_s |-> (flags_r & $past(flt_s)) == $past(flt_s))
        else $error("event did not latch its flag");
    a_irq_mask: assert property (on_s ##1 on_s |-> irq_n_pin_oe == |(flags_r & ~$past(mask_r)))
        else $error("irq pin disagrees with unmasked flags");
    a_read_clear: assert property (on_s && rd_int && flt_s == '0 ##1 on_s |-> flags_r == 8'h00)
        else $error("flag read did not clear flags");
    a_fault_rearm: assert property (rd_int && |(flt_s & ~mask_r) && on_s
                                    |-> ##[1:REARM] irq_n_pin_oe)
        else $error("persisting fault did not pull irq again");
    a_tsd_down: assert property (on_s && flt_s.thermal_shutdown_flag |=> !en_r[pfi_pkg::EN_MIR] ##1 !mirror_rails_en)
        else $error("thermal shutdown left rails on");
    a_park_seq: assert property (s_uv_entry |=> seq_r == pfi_pkg::SQ_PARK ##1 !rail_discharge)
        else $error("lockout sequence out of order");
    a_ls_fast: assert property (on_s && flt_s.ls_low |=> seq_r == pfi_pkg::SQ_DIS)
        else $error("load switch low did not discharge at once");
    a_pw_open: assert property (s_key2 and (pw_r == pfi_pkg::PW_HALF && on_s) |=> pw_r == pfi_pkg::PW_OPEN)
        else $error("password pair did not unlock");
    a_off_reset: assert property (!on_s |=> !system_reset_n_out && en_r == 2'h0 && !irq_n_pin_oe)
        else $error("power-on low did not hold defaults");
    a_aux_led: assert property (flt_s.aux_pg |=> !led_buckboost_en)
        else $error("aux rail fault left converter on");
    a_meas_none: assert property (meas_input_select == pfi_pkg::MEAS_NONE |=> meas_source_en == 10'h000)
        else $error("no-connect code selected a source");
    a_addr_wrap: assert property (@(posedge spi_clk) disable iff (serial_select_n)
                                  bits_r == 3'h7 && !cmd_r && addr_r == 7'h7F |=> addr_r == 7'h00)
        else $error("address did not wrap to zero");

endmodule // pfi_top
`default_nettype wire

// File: tb_top.sv
// Bench for the supervision block and its serial port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic              clk = 1'b0, rstn = 1'b0, pon = 1'b0, rec = 1'b1;
    pfi_pkg::pfi_flt_t flt = '0;
    wire               sclk, ssn, sdi;
    logic              so, soe, io, ioe, men, mre, led, dis, rso;
    logic [3:0]        msel;
    logic [4:0]        uth;
    logic [9:0]        msrc;
    logic [7:0]        exp_q[$];
    int                errors = 0, compares = 0, cyc = 0, seed = 17075, v;
    always #25 clk = ~clk;
    pfi_host i_host (.spi_clk(sclk), .serial_select_n(ssn), .spi_din(sdi),
                     .spi_dout_o(so), .spi_dout_oe(soe));
    pfi_top i_dut (.clk(clk), .rstn(rstn), .spi_clk(sclk), .serial_select_n(ssn),
        .spi_din(sdi), .spi_dout_o(so), .spi_dout_oe(soe), .irq_n_pin_o(io),
        .irq_n_pin_oe(ioe), .power_on_pin(pon), .flt_raw(flt), .undervoltage_lockout_flag_recovered(rec),
        .mirror_supply_enable(men), .mirror_rails_en(mre), .led_buckboost_en(led),
        .rail_discharge(dis), .system_reset_n_out(rso), .meas_input_select(msel),
        .meas_source_en(msrc), .undervoltage_lockout_flag_threshold_sel(uth));
    // ==========
    // Checks and bus helpers
    task automatic stop_test;
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer({1'b1, a}, d, 8'h00, 1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.xfer({1'b0, a}, 8'h00, 8'h00, 1);
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Read data watcher takes the oldest note
    always @(i_host.rd_stb) cmp("rd", {2'b00, exp_q.pop_front()}, {2'b00, i_host.rd_byte});
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            stop_test;
        end
    end
    // ==========
    // Main sequence
    initial begin
        wt(4);
        rstn = 1'b1;
        pon = 1'b1;
        wt(8);
        cmp("uth", 0, uth);
        cmp("io", 0, io);
        rd(7'h00, 8'h5A);
        cmp("oe", 0, soe);
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h5A);
        i_host.xfer(8'h7F, 8'h00, 8'h00, 2);
        wr(7'h09, 8'h1F);
        wr(7'h01, 8'h03);
        wt(2);
        cmp("uth", 10'h01E, uth);
        cmp("men", 1, men);
        cmp("mre", 1, mre);
        cmp("led", 1, led);
        wr(7'h11, 8'h03);
        rd(7'h11, 8'h08);
        wr(7'h10, 8'hBA);
        wr(7'h10, 8'hBE);
        rd(7'h10, 8'h01);
        for (int k = 0; k < 4; k++) begin
            v = $unsigned($random(seed)) % 16;
            wr(7'h11, v[7:0]);
            wt(2);
            cmp("msel", v[3:0], msel);
            cmp("msrc", (v == 8 || v > 9) ? 10'h000 : 10'h001 << v, msrc);
        end
        wr(7'h11, 8'h08);
        wt(2);
        cmp("msrc", 0, msrc);
        wr(7'h0D, 8'h04);
        for (int b = 0; b < 8; b++) begin
            flt = 8'h01 << b;
            wt(10);
            cmp("irq", b != 2, ioe);
            if (b == 1) cmp("men", 0, men);
            if (b == 1) cmp("mre", 0, mre);
            if (b == 7) cmp("dis", 1, dis);
            flt = '0;
            wt(8);
            rd(7'h0C, 8'h01 << b);
            wt(2);
            cmp("irq", 0, ioe);
        end
        wr(7'h01, 8'h01);
        wt(2);
        cmp("men", 0, men);
        flt.thermal_shutdown_flag = 1'b1;
        wt(8);
        rd(7'h0C, 8'h02);
        wt(3);
        cmp("irq", 1, ioe);
        flt = '0;
        pon = 1'b0;
        wt(8);
        cmp("rso", 0, rso);
        pon = 1'b1;
        wt(8);
        cmp("dis", 0, dis);
        rd(7'h0D, 8'h00);
        wr(7'h01, 8'h01);
        wt(2);
        cmp("men", 1, men);
        wr(7'h0D, 8'h10);
        flt.mirror = 1'b1;
        wt(10);
        cmp("men", 0, men);
        cmp("irq", 0, ioe);
        flt = '0;
        wt(8);
        wr(7'h01, 8'h01);
        wt(2);
        cmp("men", 1, men);
        rd(7'h0C, 8'h10);
        stop_test;
    end
endmodule // tb_top
`default_nettype wire
